//--- hdl/itfm_pkg.sv
// Package holding codes, defaults and widths for the input terminal function map
package itfm_pkg;
	localparam int          ITFM_NUM_TERM   = 5;
	localparam int          ITFM_CODE_W     = 5;
	localparam int          ITFM_POL_W      = 2;
	localparam int          ITFM_SPEED_W    = 4;
	// Function option codes
	localparam logic [4:0]  FN_FORWARD_RUN  = 5'h00;
	localparam logic [4:0]  FN_REVERSE_RUN  = 5'h01;
	localparam logic [4:0]  FN_SPEED_BIT0   = 5'h02;
	localparam logic [4:0]  FN_SPEED_BIT1   = 5'h03;
	localparam logic [4:0]  FN_SPEED_BIT2   = 5'h04;
	localparam logic [4:0]  FN_SPEED_BIT3   = 5'h05;
	localparam logic [4:0]  FN_MOTOR2_SET   = 5'h08;
	localparam logic [4:0]  FN_OUTSIDE_TRIP = 5'h0C;
	localparam logic [4:0]  FN_UNATTENDED   = 5'h0D;
	localparam logic [4:0]  FN_ANALOG_SRC   = 5'h10;
	localparam logic [4:0]  FN_RESET_CMD    = 5'h12;
	localparam logic [4:0]  FN_THERMISTOR   = 5'h13;
	// Polarity codes
	localparam logic [1:0]  POL_ACTIVE_HIGH = 2'h0;
	localparam logic [1:0]  POL_ACTIVE_LOW  = 2'h1;
	// Terminal index of the thermistor-capable terminal
	localparam int          ITFM_PTC_TERM   = 4;
	// Regional defaults, terminal 1 in the low field
	localparam logic [24:0] DEF_FN_EU  = {FN_RESET_CMD, FN_SPEED_BIT1, FN_SPEED_BIT0,
		FN_REVERSE_RUN, FN_FORWARD_RUN};
	localparam logic [24:0] DEF_FN_US  = {FN_RESET_CMD, FN_UNATTENDED, FN_ANALOG_SRC,
		FN_REVERSE_RUN, FN_FORWARD_RUN};
	localparam logic [9:0]  DEF_POL_EU = {POL_ACTIVE_HIGH, POL_ACTIVE_HIGH, POL_ACTIVE_HIGH,
		POL_ACTIVE_HIGH, POL_ACTIVE_HIGH};
	localparam logic [9:0]  DEF_POL_US = {POL_ACTIVE_HIGH, POL_ACTIVE_LOW, POL_ACTIVE_HIGH,
		POL_ACTIVE_HIGH, POL_ACTIVE_HIGH};
endpackage : itfm_pkg

//--- hdl/itfm_top.sv
// Input terminal function map: polarity, selector decode, OR-combine, trip latch
//
// Summary of operation
// - Five terminals, each with one function code per motor set
// - Separate second-motor selector for every terminal
// - Each terminal is one bit, on equals 1
// - Shared function code ORs all its terminals
// - Polarity 00 active high, 01 active low
// - Reset-function terminal ignores active-low polarity
// - Terminal five code 19 becomes thermistor input
// - Defaults: forward, reverse, reset on 1,2,5
// - EU 02/03, US 16/13 with inverted four
// - Codes 00/01 run forward/reverse while active
// - Codes 02..05 form binary speed word
// - Code 12 latches trip on rising edge
// - Code 08 selects second motor parameter set
`timescale 1ns/1ns
module itfm_top
	import itfm_pkg::*;
#(
	parameter bit US_VARIANT = 1'b0
) (
	input  wire logic                          ref_clk_in,
	input  wire logic                          reset_in,
	input  wire logic [itfm_pkg::ITFM_NUM_TERM-1:0] terminal_raw_in,
	input  wire logic                          cfg_we_in,
	input  wire logic [2:0]                    cfg_term_in,
	input  wire logic [itfm_pkg::ITFM_CODE_W-1:0]   cfg_func_in,
	input  wire logic [itfm_pkg::ITFM_CODE_W-1:0]   cfg_func_m2_in,
	input  wire logic [itfm_pkg::ITFM_POL_W-1:0]    cfg_pol_in,
	input  wire logic                          trip_clear_in,
	output logic                               forward_run_out,
	output logic                               reverse_run_out,
	output logic [itfm_pkg::ITFM_SPEED_W-1:0]  speed_select_out,
	output logic                               motor2_active_out,
	output logic                               outside_trip_out,
	output logic                               unattended_guard_out,
	output logic                               analog_source_out,
	output logic                               reset_command_out,
	output logic                               thermistor_mode_out,
	output logic [itfm_pkg::ITFM_NUM_TERM-1:0] terminal_active_out
);
	import itfm_pkg::*;

	localparam int N = ITFM_NUM_TERM;
	localparam logic [24:0] DEF_FN  = US_VARIANT ? DEF_FN_US : DEF_FN_EU;
	localparam logic [9:0]  DEF_POL = US_VARIANT ? DEF_POL_US : DEF_POL_EU;

	// Timing notes for users of this block:
	// - a terminal level reaches its decoded output on the same edge that samples it
	// - a configuration write changes the decode from the next edge, so the
	//   outputs show the new mapping two edges after the write pulse
	// - the motor-set flag is itself registered, so a change of set moves the
	//   selectors one edge later again; outputs settle within three edges
	// - terminals are taken as already synchronous; contact bounce is not
	//   filtered here and must be handled before the pins
	// - the trip flag is edge set and level cleared; a held trip input does
	//   not set it again after a clear until the input has gone inactive
	// - a code that no terminal carries simply leaves its output low
	// - the thermistor code is honoured on terminal five only; on any other
	//   terminal it selects nothing, which keeps the analog path single
	// - active low is refused at write time for the reset function, not
	//   later, so the stored polarity always matches what the decode uses

	// Decode tables and default words assume five terminals and five-bit codes;
	// any other size would silently misplace the regional defaults
	generate
		if (N != 5 || ITFM_CODE_W != 5) begin : g_bad_size
			$error("itfm_top: terminal count and code width are fixed at 5");
		end
		if (ITFM_POL_W < 1) begin : g_bad_pol
			$error("itfm_top: polarity field needs at least one bit");
		end
	endgenerate

	typedef struct packed {
		logic [N-1:0][ITFM_CODE_W-1:0] func;      // Primary selectors
		logic [N-1:0][ITFM_CODE_W-1:0] func_m2;   // Second-motor selectors
		logic [N-1:0][ITFM_POL_W-1:0]  pol;
		logic [N-1:0]                  act;       // Terminal levels after polarity
		logic                          fwd;
		logic                          rev;
		logic [ITFM_SPEED_W-1:0]       speed;
		logic                          m2;
		logic                          trip_lvl;  // Previous trip-function level
		logic                          trip;
		logic                          unattended_start_guard;
		logic                          at;
		logic                          rst_cmd;
		logic                          thermistor_input_function;
	} itfm_state_t;

	itfm_state_t state_r;
	itfm_state_t state_nxt;

	// True when any active terminal carries the given code; the OR of all
	// matching terminals is what lets one function sit on several inputs
	function automatic logic itfm_any(
		input logic [N-1:0]                  act,
		input logic [N-1:0][ITFM_CODE_W-1:0] sel,
		input logic [ITFM_CODE_W-1:0]        code
	);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < N; i++) begin
			if (act[i] && sel[i] == code) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction : itfm_any

	logic [N-1:0]                  pol_act;
	logic [N-1:0][ITFM_CODE_W-1:0] sel;

	// Polarity first, so the OR sees logical levels, not wiring sense
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_pol
			assign pol_act[g] = (state_r.pol[g] == POL_ACTIVE_LOW) ? ~terminal_raw_in[g]
				: terminal_raw_in[g];
			// Set in use follows the registered motor-2 flag to avoid a loop
			assign sel[g] = state_r.m2 ? state_r.func_m2[g] : state_r.func[g];
		end
	endgenerate

	// Next-state: configuration writes, decode, trip latch
	always_comb begin
		logic [N-1:0] act;
		logic         trip_now;
		act       = '0;
		trip_now  = 1'b0;
		state_nxt = state_r;
		// Configuration write; indices past the last terminal are dropped
		if (cfg_we_in && cfg_term_in < 3'(N)) begin
			// Both selector sets written together
			state_nxt.func[cfg_term_in]    = cfg_func_in;
			state_nxt.func_m2[cfg_term_in] = cfg_func_m2_in;
			// Active-low is refused on a reset-function terminal, in either set,
			// so a broken reset wire can never look like a held reset
			if (cfg_pol_in == POL_ACTIVE_LOW && (cfg_func_in == FN_RESET_CMD
					|| cfg_func_m2_in == FN_RESET_CMD)) begin
				state_nxt.pol[cfg_term_in] = POL_ACTIVE_HIGH;
			end else begin
				state_nxt.pol[cfg_term_in] = cfg_pol_in;
			end
		end
		// Thermistor terminal drops out of the logic decode
		for (int i = 0; i < N; i++) begin
			act[i] = pol_act[i];
			if (i == ITFM_PTC_TERM && sel[i] == FN_THERMISTOR)
				act[i] = 1'b0;
		end
		state_nxt.act      = act;
		// Run commands follow the level: active runs, inactive stops
		state_nxt.fwd      = itfm_any(act, sel, FN_FORWARD_RUN);
		state_nxt.rev      = itfm_any(act, sel, FN_REVERSE_RUN);
		// Speed word, bit 0 from the lowest speed code
		state_nxt.speed[0] = itfm_any(act, sel, FN_SPEED_BIT0);
		state_nxt.speed[1] = itfm_any(act, sel, FN_SPEED_BIT1);
		state_nxt.speed[2] = itfm_any(act, sel, FN_SPEED_BIT2);
		state_nxt.speed[3] = itfm_any(act, sel, FN_SPEED_BIT3);
		// Parameter set choice; moves the selectors one edge later
		state_nxt.m2       = itfm_any(act, sel, FN_MOTOR2_SET);
		// Plain level functions passed on to the rest of the device
		state_nxt.unattended_start_guard      = itfm_any(act, sel, FN_UNATTENDED);
		state_nxt.at       = itfm_any(act, sel, FN_ANALOG_SRC);
		state_nxt.rst_cmd  = itfm_any(act, sel, FN_RESET_CMD);
		// Thermistor mode follows the selector, not the terminal level
		state_nxt.thermistor_input_function      = (sel[ITFM_PTC_TERM] == FN_THERMISTOR);
		// Trip source level, kept to find the off-to-on transition
		trip_now           = itfm_any(act, sel, FN_OUTSIDE_TRIP);
		state_nxt.trip_lvl = trip_now;
		// Rising edge sets; set wins over a same-cycle clear, so a trip that
		// arrives while a clear is held shows for one cycle, then is cleared
		if (trip_now && !state_r.trip_lvl) begin
			state_nxt.trip = 1'b1;
		end else if (trip_clear_in || state_r.rst_cmd) begin
			// Cleared by the dedicated input or an active reset command
			state_nxt.trip = 1'b0;
		end
	end

	// Single register bank; defaults loaded at reset
	// Synchronous reset: outputs drop to zero, selectors take regional defaults
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			state_r         <= '0;
			state_r.func    <= DEF_FN;
			state_r.func_m2 <= DEF_FN;
			state_r.pol     <= DEF_POL;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Run commands
	assign forward_run_out      = state_r.fwd;
	assign reverse_run_out      = state_r.rev;
	// Speed word and motor set in use
	assign speed_select_out     = state_r.speed;
	assign motor2_active_out    = state_r.m2;
	// Sticky trip flag
	assign outside_trip_out     = state_r.trip;
	// Level functions
	assign unattended_guard_out = state_r.unattended_start_guard;
	assign analog_source_out    = state_r.at;
	assign reset_command_out    = state_r.rst_cmd;
	// Thermistor mode and post-polarity levels, for monitoring
	assign thermistor_mode_out  = state_r.thermistor_input_function;
	assign terminal_active_out  = state_r.act;
endmodule : itfm_top

//--- dv/itfm_props.sv
// Checker relating the terminal map outputs to their causes
`timescale 1ns/1ns
module itfm_props (
	input wire logic       ref_clk_in,
	input wire logic       reset_in,
	input wire logic [4:0] terminal_raw_in,
	input wire logic       cfg_we_in,
	input wire logic       trip_clear_in,
	input wire logic       forward_run_out,
	input wire logic [3:0] speed_select_out,
	input wire logic       motor2_active_out,
	input wire logic       outside_trip_out,
	input wire logic       reset_command_out,
	input wire logic       thermistor_mode_out,
	input wire logic [4:0] terminal_active_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	// Reset empties the registered outputs
	a_reset_clear: assert property (disable iff (1'b0) reset_in |=>
		speed_select_out == 4'h0 && !outside_trip_out && !motor2_active_out) else $error("reset");
	a_reset_term: assert property (disable iff (1'b0) reset_in |=>
		terminal_active_out == 5'h00 && !forward_run_out) else $error("reset term");
	// Edges pass the polarity stage one edge later; terminal five may be analog
	a_term_follow: assert property ((!reset_in && !cfg_we_in)[*3] |=>
		((terminal_active_out ^ $past(terminal_active_out)) & 5'h0F) ==
		(($past(terminal_raw_in) ^ $past(terminal_raw_in, 2)) & 5'h0F)) else $error("follow");
	// Latched trip holds until some clear
	a_trip_hold: assert property (outside_trip_out && !trip_clear_in &&
		!reset_command_out |=> outside_trip_out) else $error("trip lost");
	a_trip_clear: assert property (trip_clear_in && $stable(terminal_raw_in) &&
		$past(terminal_raw_in, 2) == terminal_raw_in |=> !outside_trip_out) else $error("clear");
	a_trip_cause: assert property ($rose(outside_trip_out) |->
		$past(terminal_raw_in) != $past(terminal_raw_in, 2)) else $error("cause");
	a_therm_blank: assert property (thermistor_mode_out |->
		!terminal_active_out[4]) else $error("therm");
	// Quiet inputs keep decoded levels still
	a_decode_still: assert property ((!reset_in && !cfg_we_in && $stable(terminal_raw_in))[*4]
		|=> $stable(speed_select_out) && $stable(forward_run_out)) else $error("still");
endmodule : itfm_props

//--- dv/itfm_switch_bank.sv
// Contact bank model driving the five terminal levels
`timescale 1ns/1ns
module itfm_switch_bank (
	input  wire logic [4:0] closed_in,
	output logic      [4:0] level_out
);
	// Closed contact reads as on, open as off
	assign level_out = closed_in;
endmodule : itfm_switch_bank

//--- dv/test_input_terminal_function_map.sv
// Testbench for the terminal map with a contact bank
`timescale 1ns/1ns
bind itfm_top itfm_props u_props (.*);
module test_input_terminal_function_map;
	import itfm_pkg::*;
	logic       ref_clk_in = 1'b0;
	logic       reset_in = 1'b1;
	logic [4:0] sw = 5'h00;
	logic [4:0] raw;
	logic       we = 1'b0;
	logic       clr = 1'b0;
	logic [2:0] term = 3'h0;
	logic [4:0] fn = 5'h00;
	logic [4:0] fn2 = 5'h00;
	logic [1:0] pol = 2'h0;
	logic       fwd, rev, m2, trip, rsc, thm;
	logic [3:0] spd;
	logic [4:0] act;
	logic       unattended_start_guard, ats, usp_us, ats_us;
	logic [4:0] act_us;
	int         fails = 0;
	int         n_checks = 0;
	itfm_switch_bank bank (.closed_in(sw), .level_out(raw));
	itfm_top uut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .terminal_raw_in(raw),
		.cfg_we_in(we), .cfg_term_in(term), .cfg_func_in(fn), .cfg_func_m2_in(fn2),
		.cfg_pol_in(pol), .trip_clear_in(clr), .forward_run_out(fwd), .reverse_run_out(rev),
		.speed_select_out(spd), .motor2_active_out(m2), .outside_trip_out(trip),
		.unattended_guard_out(unattended_start_guard), .analog_source_out(ats), .reset_command_out(rsc),
		.thermistor_mode_out(thm), .terminal_active_out(act));
	// Second copy with the other regional defaults
	itfm_top #(.US_VARIANT(1'b1)) uut_us (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
		.terminal_raw_in(raw), .cfg_we_in(we), .cfg_term_in(term), .cfg_func_in(fn),
		.cfg_func_m2_in(fn2), .cfg_pol_in(pol), .trip_clear_in(clr), .forward_run_out(),
		.reverse_run_out(), .speed_select_out(), .motor2_active_out(), .outside_trip_out(),
		.unattended_guard_out(usp_us), .analog_source_out(ats_us), .reset_command_out(),
		.thermistor_mode_out(), .terminal_active_out(act_us));
	initial forever #50 ref_clk_in = ~ref_clk_in;
	task ck(input logic [4:0] got, input logic [4:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : ck
	// One write pulse, then room for it to reach the outputs
	task cfg(input logic [2:0] t, input logic [4:0] f, input logic [4:0] f2, input logic [1:0] p);
		@(posedge ref_clk_in);
		we <= 1'b1;
		term <= t;
		fn <= f;
		fn2 <= f2;
		pol <= p;
		@(posedge ref_clk_in);
		we <= 1'b0;
		repeat (3) @(posedge ref_clk_in);
	endtask : cfg
	// Extra edge covers the motor-set lag
	task drv(input logic [4:0] v);
		@(posedge ref_clk_in);
		sw <= v;
		repeat (3) @(posedge ref_clk_in);
		#1;
	endtask : drv
	task clear_trip;
		@(posedge ref_clk_in);
		clr <= 1'b1;
		@(posedge ref_clk_in);
		clr <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		#1;
	endtask : clear_trip
	task t_defaults;
		drv(5'h01);
		ck({3'h0, fwd, rev}, 5'h02);
		ck({2'h0, act_us[3], usp_us, ats_us}, 5'h06);
		drv(5'h0E);
		ck({rev, spd}, 5'h13);
		ck({2'h0, act_us[3], usp_us, ats_us}, 5'h01);
		drv(5'h10);
		ck({rsc, act[3:0]}, 5'h10);
	endtask : t_defaults
	task t_polarity;
		cfg(3'h2, FN_FORWARD_RUN, FN_FORWARD_RUN, POL_ACTIVE_LOW);
		drv(5'h00);
		ck({3'h0, act[2], fwd}, 5'h03);
		drv(5'h04);
		ck({4'h0, fwd}, 5'h00);
		drv(5'h05);
		ck({4'h0, fwd}, 5'h01);
		cfg(3'h4, FN_RESET_CMD, FN_RESET_CMD, POL_ACTIVE_LOW);
		drv(5'h10);
		ck({4'h0, rsc}, 5'h01);
	endtask : t_polarity
	task t_trip;
		cfg(3'h1, FN_OUTSIDE_TRIP, FN_OUTSIDE_TRIP, POL_ACTIVE_HIGH);
		drv(5'h02);
		ck({4'h0, trip}, 5'h01);
		drv(5'h00);
		ck({4'h0, trip}, 5'h01);
		clear_trip();
		ck({4'h0, trip}, 5'h00);
		drv(5'h02);
		clear_trip();
		drv(5'h00);
		ck({4'h0, trip}, 5'h00);
	endtask : t_trip
	task t_aux;
		cfg(3'h1, FN_UNATTENDED, FN_UNATTENDED, POL_ACTIVE_HIGH);
		cfg(3'h2, FN_ANALOG_SRC, FN_ANALOG_SRC, POL_ACTIVE_HIGH);
		drv(5'h06);
		ck({3'h0, unattended_start_guard, ats}, 5'h03);
		drv(5'h00);
		ck({3'h0, unattended_start_guard, ats}, 5'h00);
	endtask : t_aux
	task t_motor2;
		cfg(3'h0, FN_MOTOR2_SET, FN_MOTOR2_SET, POL_ACTIVE_HIGH);
		cfg(3'h3, FN_SPEED_BIT3, FN_SPEED_BIT2, POL_ACTIVE_HIGH);
		drv(5'h08);
		ck({m2, spd}, 5'h08);
		drv(5'h09);
		ck({m2, spd}, 5'h14);
		cfg(3'h4, FN_THERMISTOR, FN_THERMISTOR, POL_ACTIVE_HIGH);
		drv(5'h19);
		ck({3'h0, thm, act[4]}, 5'h02);
	endtask : t_motor2
	task tally_and_finish;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (12) @(posedge ref_clk_in);
		reset_in <= 1'b0;
		t_defaults();
		t_polarity();
		t_trip();
		t_aux();
		t_motor2();
		tally_and_finish();
	end
endmodule : test_input_terminal_function_map
